// ---- include/mnd_pkg.sv ----
`default_nettype none
package mnd_pkg;
  // Byte offsets of the APB registers
  localparam logic [7:0] MND_OFS_CTRL  = 8'h00; // Operation launch
  localparam logic [7:0] MND_OFS_STAT  = 8'h04; // Busy state
  localparam logic [7:0] MND_OFS_WREG  = 8'h08; // Working register
  localparam logic [7:0] MND_OFS_BANK  = 8'h0c; // Bank select register
  localparam logic [7:0] MND_OFS_FLAGS = 8'h10; // Arithmetic flags
  localparam logic [7:0] MND_OFS_PRODUCT_HIGH = 8'h14; // Product high byte
  localparam logic [7:0] MND_OFS_PRODUCT_LOW = 8'h18; // Product low byte
  localparam logic [7:0] MND_OFS_MADDR = 8'h1c; // Memory window address
  localparam logic [7:0] MND_OFS_MDATA = 8'h20; // Memory window data

  // Control word fields
  localparam int MND_CTRL_FADDR_LSB = 0;  // File address byte
  localparam int MND_CTRL_LIT_LSB   = 8;  // Immediate literal byte
  localparam int MND_CTRL_OP_LSB    = 16; // Two-bit operation code
  localparam int MND_CTRL_ACC_BIT   = 18; // Access-select bit

  // Operation codes
  localparam logic [1:0] MND_OP_NONE   = 2'h0;
  localparam logic [1:0] MND_OP_MULF   = 2'h1; // multiply_by_file
  localparam logic [1:0] MND_OP_MULLIT = 2'h2; // multiply_by_literal
  localparam logic [1:0] MND_OP_NEGATE_FILE   = 2'h3; // negate_file

  // Flag bit positions, then the flag field width
  localparam int MND_FLAG_C  = 0;
  localparam int MND_FLAG_DC = 1;
  localparam int MND_FLAG_Z  = 2;
  localparam int MND_FLAG_OV = 3;
  localparam int MND_FLAG_N  = 4;
  localparam int MND_FLAG_W  = 5;

  // Reset values
  localparam logic [7:0] MND_RST_BYTE  = 8'h00;
  localparam logic [4:0] MND_RST_FLAGS = 5'h00;

  // Four-phase instruction sequencer, one-hot
  typedef enum logic [4:0] {
    MND_IDLE = 5'b00001,
    MND_Q1   = 5'b00010,
    MND_Q2   = 5'b00100,
    MND_Q3   = 5'b01000,
    MND_Q4   = 5'b10000
  } mnd_state_e;
endpackage
`default_nettype wire

// ---- hw/mnd_datapath.sv ----
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Multiply treats both operands as unsigned
// - Full sixteen-bit product is kept
// - High byte to high, low to low
// - Multiply writes only the product pair
// - Multiply leaves all flags untouched
// - Zero product raises no zero flag
// - Access bit 0 selects common access bank
// - Access bit 1 uses bank select register
// - Negate is invert plus one
// - Negated byte returns to its source
// - Literal multiply uses immediate byte
module mnd_datapath #(
  parameter int BANK_W = 4 // Bank select width
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic        pready,
  output var  logic [31:0] prdata,
  output var  logic        pslverr,
  output var  logic        busy
);
  import mnd_pkg::*;

  localparam int MADDR_W = BANK_W + 8;        // Full data address width
  localparam int DEPTH   = 1 << MADDR_W;      // Bytes of data memory

  // Data memory, all banks
  logic [7:0]         mem [DEPTH];
  // Sequencer state
  mnd_state_e         state_q;
  // Latched operation and its operands
  logic [1:0]         op_q;
  logic               acc_q;
  logic [7:0]         faddr_q;
  logic [7:0]         lit_q;
  logic [MADDR_W-1:0] eff_q;      // Resolved operand address
  logic [7:0]         opnd_q;     // Second operand byte
  logic [15:0]        result_q;   // Product or negated byte
  logic [4:0]         nflags_q;   // Flags produced by negate
  // Architectural registers
  logic [7:0]         wreg_q;
  logic [BANK_W-1:0]  bank_select_register_q;
  logic [4:0]         flags_q;
  logic [7:0]         product_high_q;
  logic [7:0]         product_low_q;
  logic [MADDR_W-1:0] maddr_q;
  // APB answer registers
  logic               pready_q;
  logic [31:0]        prdata_q;
  logic               pslverr_q;
  // Decoded bus events
  logic               acc_first;  // First access cycle
  logic               wr_commit;  // Write takes effect now
  logic               mapped;
  logic [31:0]        rd_d;
  logic               idle;
  // Negate arithmetic
  logic [8:0]         neg_sum;
  logic [4:0]         neg_lo;
  logic [7:0]         neg_inv;

  // Bus events are decoded without the enable; every register that
  // acts on them is gated by ce itself, so a frozen core holds its
  // answer, and a write whose completing edge has ce low is dropped.
  assign idle      = (state_q == MND_IDLE);
  assign acc_first = psel && penable && !pready_q;
  assign wr_commit = psel && penable && pready_q && pwrite;

  // Operand address resolution for the file operations
  function automatic logic [MADDR_W-1:0] resolve(
    input logic              a,
    input logic [7:0]        f,
    input logic [BANK_W-1:0] bsel
  );
    logic [BANK_W-1:0] b;
    b = bsel;
    if (!a) begin
      // Low half in bank 0, high half in the top bank
      b = f[7] ? {BANK_W{1'b1}} : {BANK_W{1'b0}};
    end
    return {b, f};
  endfunction

  // Register map decode and read data
  always_comb begin
    mapped = 1'b1;
    rd_d   = 32'h0000_0000;
    unique case (paddr)
      MND_OFS_CTRL: begin
        rd_d[MND_CTRL_FADDR_LSB +: 8] = faddr_q;
        rd_d[MND_CTRL_LIT_LSB +: 8]   = lit_q;
        rd_d[MND_CTRL_OP_LSB +: 2]    = op_q;
        rd_d[MND_CTRL_ACC_BIT]        = acc_q;
      end
      MND_OFS_STAT:  rd_d[0] = !idle;
      MND_OFS_WREG:  rd_d[7:0] = wreg_q;
      MND_OFS_BANK:  rd_d[BANK_W-1:0] = bank_select_register_q;
      MND_OFS_FLAGS: rd_d[MND_FLAG_W-1:0] = flags_q;
      MND_OFS_PRODUCT_HIGH: rd_d[7:0] = product_high_q;
      MND_OFS_PRODUCT_LOW: rd_d[7:0] = product_low_q;
      MND_OFS_MADDR: rd_d[MADDR_W-1:0] = maddr_q;
      MND_OFS_MDATA: rd_d[7:0] = mem[maddr_q];
      default:       mapped = 1'b0;
    endcase
  end

  // APB answer: one wait cycle, then ready with data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      if (acc_first) begin
        // Capture the answer for the next edge
        pready_q  <= 1'b1;
        prdata_q  <= pwrite ? 32'h0000_0000 : rd_d;
        pslverr_q <= !mapped;
      end else begin
        // Release after the completing edge
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  // Instruction sequencer through the four phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= MND_IDLE;
    end else if (ce) begin
      unique case (state_q)
        MND_IDLE: begin
          // Launch on a control write with a real opcode
          if (wr_commit && paddr == MND_OFS_CTRL &&
              pwdata[MND_CTRL_OP_LSB +: 2] != MND_OP_NONE) begin
            state_q <= MND_Q1;
          end
        end
        MND_Q1: state_q <= MND_Q2;
        MND_Q2: state_q <= MND_Q3;
        MND_Q3: state_q <= MND_Q4;
        MND_Q4: state_q <= MND_IDLE;
      endcase
    end
  end

  // Control word capture, only while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q    <= MND_OP_NONE;
      acc_q   <= 1'b1;
      faddr_q <= MND_RST_BYTE;
      lit_q   <= MND_RST_BYTE;
    end else if (ce && idle && wr_commit && paddr == MND_OFS_CTRL) begin
      op_q    <= pwdata[MND_CTRL_OP_LSB +: 2];
      acc_q   <= pwdata[MND_CTRL_ACC_BIT];
      faddr_q <= pwdata[MND_CTRL_FADDR_LSB +: 8];
      lit_q   <= pwdata[MND_CTRL_LIT_LSB +: 8];
    end
  end

  // Decode phase resolves the address; read phase fetches operand
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eff_q  <= '0;
      opnd_q <= MND_RST_BYTE;
    end else if (ce) begin
      if (state_q == MND_Q1) begin
        eff_q <= resolve(acc_q, faddr_q, bank_select_register_q);
      end
      if (state_q == MND_Q2) begin
        // Literal comes from the instruction, else from memory
        opnd_q <= (op_q == MND_OP_MULLIT) ? lit_q : mem[eff_q];
      end
    end
  end

  // Negate arithmetic as inverted operand plus one
  assign neg_inv = ~opnd_q;
  assign neg_sum = {1'b0, neg_inv} + 9'h001;
  assign neg_lo  = {1'b0, neg_inv[3:0]} + 5'h01;

  // Process phase forms the result and new flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= 16'h0000;
      nflags_q <= MND_RST_FLAGS;
    end else if (ce && state_q == MND_Q3) begin
      if (op_q == MND_OP_NEGATE_FILE) begin
        result_q <= {8'h00, neg_sum[7:0]};
        nflags_q[MND_FLAG_C]  <= neg_sum[8];
        nflags_q[MND_FLAG_DC] <= neg_lo[4];
        nflags_q[MND_FLAG_Z]  <= (neg_sum[7:0] == 8'h00);
        nflags_q[MND_FLAG_N]  <= neg_sum[7];
        // Signed overflow: positive plus one went negative
        nflags_q[MND_FLAG_OV] <= !neg_inv[7] && neg_sum[7];
      end else begin
        // Unsigned full-width product, never truncated
        result_q <= {8'h00, wreg_q} * {8'h00, opnd_q};
      end
    end
  end

  // Working register, software only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wreg_q <= MND_RST_BYTE;
    end else if (ce && idle && wr_commit && paddr == MND_OFS_WREG) begin
      wreg_q <= pwdata[7:0];
    end
  end

  // Bank select register, software only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_select_register_q <= '0;
    end else if (ce && idle && wr_commit && paddr == MND_OFS_BANK) begin
      bank_select_register_q <= pwdata[BANK_W-1:0];
    end
  end

  // Flags change only by software or by a negate write phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= MND_RST_FLAGS;
    end else if (ce) begin
      if (state_q == MND_Q4 && op_q == MND_OP_NEGATE_FILE) begin
        flags_q <= nflags_q;
      end else if (idle && wr_commit && paddr == MND_OFS_FLAGS) begin
        flags_q <= pwdata[MND_FLAG_W-1:0];
      end
      // Multiplies fall through with flags held, zero or not
    end
  end

  // Product pair written in the write phase of a multiply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      product_high_q <= MND_RST_BYTE;
      product_low_q  <= MND_RST_BYTE;
    end else if (ce && state_q == MND_Q4 && op_q != MND_OP_NEGATE_FILE) begin
      product_high_q <= result_q[15:8];
      product_low_q  <= result_q[7:0];
    end
  end

  // Memory window address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maddr_q <= '0;
    end else if (ce && wr_commit && paddr == MND_OFS_MADDR) begin
      maddr_q <= pwdata[MADDR_W-1:0];
    end
  end

  // Data memory: negate write-back, else software window write
  always_ff @(posedge pclk) begin
    if (ce) begin
      if (state_q == MND_Q4 && op_q == MND_OP_NEGATE_FILE) begin
        mem[eff_q] <= result_q[7:0];
      end else if (idle && wr_commit && paddr == MND_OFS_MDATA) begin
        mem[maddr_q] <= pwdata[7:0];
      end
    end
  end

  // Busy indicator for the core side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
    end else if (ce) begin
      busy <= !(state_q == MND_Q4 ||
                (idle && !(wr_commit && paddr == MND_OFS_CTRL &&
                 pwdata[MND_CTRL_OP_LSB +: 2] != MND_OP_NONE)));
    end
  end

  // Outputs straight from flip-flops
  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
endmodule
`default_nettype wire

// ---- verif/mnd_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module mnd_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        busy
);
  import mnd_pkg::*;
  // One clock domain for every check
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Commit edge of a control write that starts an operation
  sequence s_launch;
    ce && psel && penable && pready && pwrite && paddr == MND_OFS_CTRL &&
      pwdata[MND_CTRL_OP_LSB +: 2] != MND_OP_NONE && !busy;
  endsequence
  // Four phases then idle
  sequence s_run;
    busy [*4] ##1 !busy;
  endsequence
  property p_busy_span; s_launch |=> s_run; endproperty
  a_busy_span: assert property (p_busy_span)
    else $error("operation span wrong");
  property p_rdy_pulse; pready && ce |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
  property p_rdy_cause; $rose(pready) |-> $past(psel && penable); endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("pready unasked");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr alone");
  property p_wr_zero; pready && pwrite |-> prdata == 32'h0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write data not 0");
  property p_unmapped;
    pready && (paddr > MND_OFS_MDATA || paddr[1:0] != 2'h0) |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no slave error");
  property p_mapped;
    pready && paddr <= MND_OFS_MDATA && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("false slave error");
  property p_stat;
    $rose(pready) && $past(ce) && !pwrite && paddr == MND_OFS_STAT
      |-> prdata == {31'h0, $past(busy)};
  endproperty
  a_stat: assert property (p_stat) else $error("status busy wrong");
endmodule
`default_nettype wire

// ---- verif/mnd_core_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module mnd_core_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic stall,
  output var  logic ce
);
  // Core enable: steady, or every other cycle while the core stalls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce <= 1'b1;
    end else begin
      ce <= !stall || !ce;
    end
  end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin n_errors++; \
  $display("BAD %0t got %h want %h", $time, g, x); end end
module testbench;
  import mnd_pkg::*;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic        busy, stall;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          n_errors, checks_done;
  mnd_datapath i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .busy(busy));
  mnd_core_model i_core (.pclk(pclk), .presetn(presetn), .stall(stall),
    .ce(ce));
  // Clock of 40 ns
  always #20 pclk = !pclk;
  // One APB transfer, waiting for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r; logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r; logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r, x)
  endtask
  // Launch an operation and poll status until idle
  task automatic go(input logic [1:0] op, input logic ac,
                    input logic [7:0] k, input logic [7:0] f);
    logic [31:0] r; logic e; int n;
    wr(MND_OFS_CTRL, {13'h0, ac, op, k, f});
    n = 0;
    do begin apb(1'b0, MND_OFS_STAT, 32'h0, r, e); n++; end
      while (r !== 32'h0 && n < 20);
    if (n >= 20) n_errors++;
  endtask
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    n_errors++;
    final_report();
  end
  // Negate table: operand, result, flags
  logic [7:0] ng [3][3] = '{'{8'h3a, 8'hc6, 8'h10}, '{8'h00, 8'h00, 8'h07},
                            '{8'h80, 8'h80, 8'h1a}};
  initial begin
    logic [31:0] r; logic e;
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; stall = 0;
    paddr = 8'h00; pwdata = 32'h0; n_errors = 0; checks_done = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    stall <= 1'b1;
    rd(MND_OFS_CTRL, 32'h00040000);
    rd(MND_OFS_FLAGS, 32'h0);
    apb(1'b0, 8'h24, 32'h0, r, e);
    `CHK(e, 1'b1)
    stall <= 1'b0;
    wr(MND_OFS_WREG, 32'he2);
    go(MND_OP_MULLIT, 1'b1, 8'hc4, 8'h00);
    rd(MND_OFS_PRODUCT_HIGH, 32'had);
    rd(MND_OFS_PRODUCT_LOW, 32'h08);
    wr(MND_OFS_BANK, 32'h3);
    wr(MND_OFS_MADDR, 32'h325);
    wr(MND_OFS_MDATA, 32'hb5);
    wr(MND_OFS_WREG, 32'hc4);
    wr(MND_OFS_FLAGS, 32'h1f);
    go(MND_OP_MULF, 1'b1, 8'h00, 8'h25);
    rd(MND_OFS_PRODUCT_HIGH, 32'h8a);
    rd(MND_OFS_PRODUCT_LOW, 32'h94);
    rd(MND_OFS_MDATA, 32'hb5);
    rd(MND_OFS_WREG, 32'hc4);
    rd(MND_OFS_FLAGS, 32'h1f);
    wr(MND_OFS_MADDR, 32'h025);
    wr(MND_OFS_MDATA, 32'h11);
    wr(MND_OFS_MADDR, 32'hf85);
    wr(MND_OFS_MDATA, 32'h03);
    go(MND_OP_MULF, 1'b0, 8'h00, 8'h25);
    rd(MND_OFS_PRODUCT_HIGH, 32'h0d);
    rd(MND_OFS_PRODUCT_LOW, 32'h04);
    go(MND_OP_MULF, 1'b0, 8'h00, 8'h85);
    rd(MND_OFS_PRODUCT_HIGH, 32'h02);
    rd(MND_OFS_PRODUCT_LOW, 32'h4c);
    wr(MND_OFS_FLAGS, 32'h0);
    wr(MND_OFS_WREG, 32'h0);
    go(MND_OP_MULF, 1'b1, 8'h00, 8'h25);
    rd(MND_OFS_PRODUCT_LOW, 32'h0);
    rd(MND_OFS_FLAGS, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(MND_OFS_MADDR, 32'h325);
      wr(MND_OFS_MDATA, {24'h0, ng[i][0]});
      go(MND_OP_NEGATE_FILE, 1'b1, 8'h00, 8'h25);
      rd(MND_OFS_MDATA, {24'h0, ng[i][1]});
      rd(MND_OFS_FLAGS, {24'h0, ng[i][2]});
    end
    final_report();
  end
endmodule
bind mnd_datapath mnd_chk i_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .busy(busy));
`default_nettype wire
